//--- design/tcu_capture_ch.v
// one capture channel: source select, synchroniser, edge detect, prescaler, value latch
// assumes timer count and control fields on core_clk_in; sources are asynchronous
`timescale 1ns/100ps
`include "tcu_regs.vh"
module tcu_capture_ch #(
    parameter WIDTH = 16
) (
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    input  wire [7:0]       ctrl_in,
    input  wire [2:0]       src_sel_in,
    input  wire [7:0]       sources_in,
    input  wire [WIDTH-1:0] timer_in,
    output reg  [WIDTH-1:0] value_ff_out,
    output reg              capture_ff_out
);
    reg  [2:0]       sync_ff;
    reg              level_ff;
    reg  [3:0]       ps_ff;
    reg  [3:0]       nxt_ps;
    reg              nxt_cap;
    wire [3:0]       mode = ctrl_in[`TCU_CTL_MODE_LSB+3:`TCU_CTL_MODE_LSB];
    wire             en   = ctrl_in[`TCU_CTL_EN_BIT];
    wire             cap_mode = (mode[3:2] == 2'b01);
    // only stages two and three are compared
    wire             agree = (sync_ff[1] == sync_ff[2]);
    wire             rise = agree && sync_ff[2] && !level_ff;
    wire             fall = agree && !sync_ff[2] && level_ff;

    always @* begin
        nxt_ps  = ps_ff;
        nxt_cap = 1'b0;
        if (!en || !cap_mode) begin
            nxt_ps = 4'h0;
        end else begin
            case (mode)
                `TCU_MODE_FALL: begin
                    nxt_cap = fall;
                end
                `TCU_MODE_RISE: begin
                    nxt_cap = rise;
                end
                `TCU_MODE_RISE4: begin
                    if (rise) begin
                        nxt_cap = ({2'b00, ps_ff[1:0]} == `TCU_PS4_LAST);
                        nxt_ps  = ps_ff + 4'h1;
                    end
                end
                `TCU_MODE_RISE16: begin
                    if (rise) begin
                        nxt_cap = (ps_ff == `TCU_PS16_LAST);
                        nxt_ps  = ps_ff + 4'h1;
                    end
                end
                default: begin
                    nxt_cap = 1'b0;
                end
            endcase
        end
    end

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync_ff        <= 3'h0;
            level_ff       <= 1'b0;
            ps_ff          <= 4'h0;
            value_ff_out   <= {WIDTH{1'b0}};
            capture_ff_out <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], sources_in[src_sel_in]};
            if (agree) begin
                level_ff <= sync_ff[2];
            end
            ps_ff          <= nxt_ps;
            capture_ff_out <= nxt_cap;
            if (nxt_cap) begin
                value_ff_out <= timer_in;
            end
        end
    end
endmodule // tcu_capture_ch

//--- design/tcu_regs.vh
// register map, field positions and reset values of the timer capture unit
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef TCU_REGS_VH
`define TCU_REGS_VH
`define TCU_CTRL1_ADDR     8'h00
`define TCU_CTRL2_ADDR     8'h04
`define TCU_SRC1_ADDR      8'h08
`define TCU_SRC2_ADDR      8'h0c
`define TCU_VAL1_ADDR      8'h10
`define TCU_VAL2_ADDR      8'h14
`define TCU_FLAG_ADDR      8'h18
`define TCU_MASK_ADDR      8'h1c
`define TCU_TIMER_ADDR     8'h20
`define TCU_CTL_EN_BIT     7
`define TCU_CTL_FMT_BIT    4
`define TCU_CTL_MODE_LSB   0
`define TCU_CTRL_RST       8'h00
`define TCU_SRC_RST        3'h0
`define TCU_MASK_RST       2'h0
`define TCU_FLAG_RST       2'h0
`define TCU_MODE_FALL      4'h4
`define TCU_MODE_RISE      4'h5
`define TCU_MODE_RISE4     4'h6
`define TCU_MODE_RISE16    4'h7
`define TCU_PS4_LAST       4'h3
`define TCU_PS16_LAST      4'hf
`define TCU_RESP_OKAY      2'b00
`define TCU_RESP_SLVERR    2'b10
`endif

//--- design/tcu_top.v
// timer capture unit: two capture channels, free running timer, axi4-lite registers
// assumes one 20 MHz clock; source inputs are asynchronous pins or peripheral outputs
// What this block does
// - capture copies full 16-bit timer count into the channel value register
// - modes: every falling, rising, fourth rising, sixteenth rising edge
// - each capture sets the capture event flag
// - flag stays set until software clears it
// - a newer capture overwrites an unread stored value
// - three-bit field selects one of eight capture sources
// - pin edge seen from pin level, so port writes may capture
// - prescaler held at zero when disabled or not capturing
// - every reset clears the prescaler counter
// - prescale change without clearing control may raise false flag
// - two identical channels, each with own control, value and flag
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "tcu_regs.vh"
module tcu_top #(
    parameter WIDTH = 16
) (
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        timer_run_in,
    input  wire        capture_pin_one_in,
    input  wire        capture_pin_two_in,
    input  wire        comparator_one_sync_out_in,
    input  wire        comparator_two_sync_out_in,
    input  wire        pin_change_event_in,
    input  wire        logic_cell_one_out_in,
    input  wire        logic_cell_two_out_in,
    input  wire        logic_cell_three_out_in,
    input  wire        logic_cell_four_out_in,
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    output reg         irq_ff_out
);
    reg  [7:0]       ctrl1_ff;
    reg  [7:0]       ctrl2_ff;
    reg  [2:0]       src1_ff;
    reg  [2:0]       src2_ff;
    reg  [1:0]       flag_ff;
    reg  [1:0]       mask_ff;
    reg  [WIDTH-1:0] timer_ff;
    reg  [2:0]       run_sync_ff;
    reg              run_ff;
    reg  [7:0]       aw_addr_ff;
    reg              aw_have_ff;
    reg  [31:0]      w_data_ff;
    reg  [3:0]       w_strb_ff;
    reg              w_have_ff;
    wire [WIDTH-1:0] val1;
    wire [WIDTH-1:0] val2;
    wire             cap1;
    wire             cap2;
    wire             do_write = aw_have_ff && w_have_ff && !s_axi_bvalid_out;
    wire             do_read  = s_axi_arvalid_in && s_axi_arready_out;
    wire [1:0]       nxt_flag;
    wire [1:0]       flag_clr;
    wire [31:0]      rd_word;
    wire             rd_hit;

    // pick low byte lane for 8-bit register writes
    function [7:0] tcu_lane0;
        input [7:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            tcu_lane0 = strb[0] ? data[7:0] : old_val;
        end
    endfunction

    // align capture value into word, fmt bit left-justifies
    function [31:0] tcu_align;
        input [WIDTH-1:0] val;
        input fmt;
        begin
            tcu_align = fmt ? {val, 16'h0000} : {16'h0000, val};
        end
    endfunction

    // pin taken as the raw pin level
    wire [7:0] srcs1 = {logic_cell_four_out_in, logic_cell_three_out_in,
                        logic_cell_two_out_in, logic_cell_one_out_in,
                        pin_change_event_in, comparator_two_sync_out_in,
                        comparator_one_sync_out_in, capture_pin_one_in};
    wire [7:0] srcs2 = {srcs1[7:1], capture_pin_two_in};

    tcu_capture_ch #(.WIDTH(WIDTH)) u_ch1 (
        .core_clk_in    (core_clk_in),
        .rst_n_in       (rst_n_in),
        .ctrl_in        (ctrl1_ff),
        .src_sel_in     (src1_ff),
        .sources_in     (srcs1),
        .timer_in       (timer_ff),
        .value_ff_out   (val1),
        .capture_ff_out (cap1)
    );

    tcu_capture_ch #(.WIDTH(WIDTH)) u_ch2 (
        .core_clk_in    (core_clk_in),
        .rst_n_in       (rst_n_in),
        .ctrl_in        (ctrl2_ff),
        .src_sel_in     (src2_ff),
        .sources_in     (srcs2),
        .timer_in       (timer_ff),
        .value_ff_out   (val2),
        .capture_ff_out (cap2)
    );

    // free running count on instruction clock, gated by a synchronised run level
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            run_sync_ff <= 3'h0;
            run_ff      <= 1'b0;
            timer_ff    <= {WIDTH{1'b0}};
        end else begin
            run_sync_ff <= {run_sync_ff[1:0], timer_run_in};
            if (run_sync_ff[1] == run_sync_ff[2]) begin
                run_ff <= run_sync_ff[2];
            end
            if (run_ff) begin
                timer_ff <= timer_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign flag_clr = (do_write && aw_addr_ff == `TCU_FLAG_ADDR && w_strb_ff[0]) ?
                      w_data_ff[1:0] : 2'b00;
    // sticky until written one; set wins over clear
    assign nxt_flag = (flag_ff & ~flag_clr) | {cap2, cap1};

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            aw_addr_ff        <= 8'h00;
            aw_have_ff        <= 1'b0;
            w_data_ff         <= 32'h0000_0000;
            w_strb_ff         <= 4'h0;
            w_have_ff         <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `TCU_RESP_OKAY;
            ctrl1_ff          <= `TCU_CTRL_RST;
            ctrl2_ff          <= `TCU_CTRL_RST;
            src1_ff           <= `TCU_SRC_RST;
            src2_ff           <= `TCU_SRC_RST;
            mask_ff           <= `TCU_MASK_RST;
            flag_ff           <= `TCU_FLAG_RST;
            irq_ff_out        <= 1'b0;
        end else begin
            flag_ff    <= nxt_flag;
            irq_ff_out <= |(nxt_flag & mask_ff);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr_ff        <= s_axi_awaddr_in;
                aw_have_ff        <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data_ff        <= s_axi_wdata_in;
                w_strb_ff        <= s_axi_wstrb_in;
                w_have_ff        <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_have_ff       <= 1'b0;
                w_have_ff        <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= `TCU_RESP_OKAY;
                case (aw_addr_ff)
                    `TCU_CTRL1_ADDR: begin
                        ctrl1_ff <= tcu_lane0(ctrl1_ff, w_data_ff, w_strb_ff) & 8'hbf;
                    end
                    `TCU_CTRL2_ADDR: begin
                        ctrl2_ff <= tcu_lane0(ctrl2_ff, w_data_ff, w_strb_ff) & 8'hbf;
                    end
                    `TCU_SRC1_ADDR: begin
                        src1_ff <= w_strb_ff[0] ? w_data_ff[2:0] : src1_ff;
                    end
                    `TCU_SRC2_ADDR: begin
                        src2_ff <= w_strb_ff[0] ? w_data_ff[2:0] : src2_ff;
                    end
                    `TCU_MASK_ADDR: begin
                        mask_ff <= w_strb_ff[0] ? w_data_ff[1:0] : mask_ff;
                    end
                    `TCU_FLAG_ADDR: begin
                        s_axi_bresp_out <= `TCU_RESP_OKAY;
                    end
                    `TCU_VAL1_ADDR, `TCU_VAL2_ADDR, `TCU_TIMER_ADDR: begin
                        s_axi_bresp_out <= `TCU_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_out <= `TCU_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    assign rd_hit  = (s_axi_araddr_in == `TCU_CTRL1_ADDR) ||
                     (s_axi_araddr_in == `TCU_CTRL2_ADDR) ||
                     (s_axi_araddr_in == `TCU_SRC1_ADDR)  ||
                     (s_axi_araddr_in == `TCU_SRC2_ADDR)  ||
                     (s_axi_araddr_in == `TCU_VAL1_ADDR)  ||
                     (s_axi_araddr_in == `TCU_VAL2_ADDR)  ||
                     (s_axi_araddr_in == `TCU_FLAG_ADDR)  ||
                     (s_axi_araddr_in == `TCU_MASK_ADDR)  ||
                     (s_axi_araddr_in == `TCU_TIMER_ADDR);
    assign rd_word =
        (s_axi_araddr_in == `TCU_CTRL1_ADDR) ? {24'h0, ctrl1_ff} :
        (s_axi_araddr_in == `TCU_CTRL2_ADDR) ? {24'h0, ctrl2_ff} :
        (s_axi_araddr_in == `TCU_SRC1_ADDR)  ? {29'h0, src1_ff} :
        (s_axi_araddr_in == `TCU_SRC2_ADDR)  ? {29'h0, src2_ff} :
        (s_axi_araddr_in == `TCU_VAL1_ADDR)  ? tcu_align(val1, ctrl1_ff[`TCU_CTL_FMT_BIT]) :
        (s_axi_araddr_in == `TCU_VAL2_ADDR)  ? tcu_align(val2, ctrl2_ff[`TCU_CTL_FMT_BIT]) :
        (s_axi_araddr_in == `TCU_FLAG_ADDR)  ? {30'h0, flag_ff} :
        (s_axi_araddr_in == `TCU_MASK_ADDR)  ? {30'h0, mask_ff} :
        (s_axi_araddr_in == `TCU_TIMER_ADDR) ? {16'h0, timer_ff} : 32'h0000_0000;

    // reads have no side effect; the capture value may be overwritten at any time
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `TCU_RESP_OKAY;
        end else begin
            if (do_read) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out  <= 1'b1;
                s_axi_rdata_out   <= rd_word;
                s_axi_rresp_out   <= rd_hit ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
            end
            if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out  <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end
endmodule // tcu_top

//--- tb/tcu_event_src.sv
// event source model: pin and peripheral levels feeding the capture unit
// assumes callers run on the same clock; lines idle low
`timescale 1ns/100ps
module tcu_event_src (
    input  wire       core_clk_in,
    output reg  [8:0] lines_out
);
    initial lines_out = 9'h000;
    // 4 cycles each way, above the 2-cycle synchroniser minimum
    task pulse(input integer idx);
        begin
            @(posedge core_clk_in);
            lines_out[idx] <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            lines_out[idx] <= 1'b0;
            repeat (4) @(posedge core_clk_in);
        end
    endtask
endmodule // tcu_event_src

//--- tb/tcu_top_asserts.sv
// port-level checker for the capture unit top, bound into every instance
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
module tcu_top_asserts #(
    parameter WIDTH = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic irq_ff_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_rst_idle;
        $rose(rst_n_in) |-> !irq_ff_out && s_axi_arready_out && s_axi_awready_out;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("state after reset wrong");
    // irq only drops after software writes a flag or mask
    property p_irq_sticky;
        $fell(irq_ff_out) |-> $past(s_axi_wvalid_in && s_axi_wready_out)
            || $past(s_axi_wvalid_in && s_axi_wready_out, 2)
            || $past(s_axi_wvalid_in && s_axi_wready_out, 3);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without write");
    property p_r_lat;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_lat;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |-> ##[1:2] s_axi_bvalid_out;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_w_block;
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write accepted while busy");
    property p_r_block;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read accepted while busy");
    property p_b_done;
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response not retired");
    property p_r_done;
        s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read response not retired");
endmodule // tcu_top_asserts

bind tcu_top tcu_top_asserts #(.WIDTH(WIDTH)) u_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .irq_ff_out(irq_ff_out)
);

//--- tb/timer_capture_unit_tb.sv
// capture unit testbench: axi4-lite master tasks, one task per scenario
// assumes tcu_event_src drives all event lines; bench controls timer run
`timescale 1ns/100ps
`include "tcu_regs.vh"
module timer_capture_unit_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         run = 1'b0;
    reg  [7:0]  aw_a = 8'h00;
    reg  [7:0]  ar_a = 8'h00;
    reg  [31:0] wd = 32'h0;
    reg         awv = 1'b0;
    reg         wv = 1'b0;
    reg         brd = 1'b0;
    reg         arv = 1'b0;
    reg         rrd = 1'b0;
    wire        awr, w_r, bv, arr, rv, irq;
    wire [1:0]  br, rr;
    wire [31:0] rdat;
    wire [8:0]  ln;
    integer     miscompares = 0;
    integer     n_checks = 0;
    reg  [31:0] rd;
    reg  [1:0]  rsp;
    always #25 clk = ~clk;
    tcu_event_src src (.core_clk_in(clk), .lines_out(ln));
    tcu_top dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .timer_run_in(run),
        .capture_pin_one_in(ln[0]), .capture_pin_two_in(ln[1]),
        .comparator_one_sync_out_in(ln[2]), .comparator_two_sync_out_in(ln[3]),
        .pin_change_event_in(ln[4]), .logic_cell_one_out_in(ln[5]),
        .logic_cell_two_out_in(ln[6]), .logic_cell_three_out_in(ln[7]),
        .logic_cell_four_out_in(ln[8]), .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(w_r), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_araddr_in(ar_a),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd),
        .irq_ff_out(irq));
    task finish_test;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // waits for the answer however long it takes; only the watchdog ends a hang
    task reg_wr(input [7:0] a, input [31:0] d);
        reg [1:0] took;
        reg       done;
        begin
            took = 2'b00;
            done = 1'b0;
            @(posedge clk);
            aw_a <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            brd <= 1'b1;
            while (!done) begin
                @(posedge clk);
                if (awv && awr) begin
                    took[1] = 1'b1;
                    awv <= 1'b0;
                end
                if (wv && w_r) begin
                    took[0] = 1'b1;
                    wv <= 1'b0;
                end
                if (bv) begin
                    rsp = br;
                    brd <= 1'b0;
                    done = 1'b1;
                end
            end
            // response must follow both address and data
            chk("wr_ord", 32'h3, {30'h0, took});
        end
    endtask
    task reg_rd(input [7:0] a);
        reg took;
        reg done;
        begin
            took = 1'b0;
            done = 1'b0;
            @(posedge clk);
            ar_a <= a;
            arv <= 1'b1;
            rrd <= 1'b1;
            while (!done) begin
                @(posedge clk);
                if (arv && arr) begin
                    took = 1'b1;
                    arv <= 1'b0;
                end
                if (rv) begin
                    rd = rdat;
                    rsp = rr;
                    rrd <= 1'b0;
                    done = 1'b1;
                end
            end
            chk("rd_ord", 32'h1, {31'h0, took});
        end
    endtask
    task rchk(input [8*6-1:0] nm, input [7:0] a, input [31:0] e);
        begin
            reg_rd(a);
            chk(nm, e, rd);
        end
    endtask
    task ev(input integer ch, input integer k);
        src.pulse(k == 0 ? ch : k + 1);
    endtask
    task wt;
        repeat (10) @(posedge clk);
    endtask
    // timer counts on the core clock, then is parked for a known value
    task tsnap(output [31:0] v);
        begin
            run <= 1'b1;
            repeat (7) @(posedge clk);
            run <= 1'b0;
            repeat (8) @(posedge clk);
            reg_rd(`TCU_TIMER_ADDR);
            v = rd & 32'hffff;
        end
    endtask
    task irqchk(input e);
        begin
            repeat (2) @(posedge clk);
            #1 chk("irq", {31'h0, e}, {31'h0, irq});
        end
    endtask
    task t_reset;
        begin
            rchk("ctrl1", `TCU_CTRL1_ADDR, 0);
            rchk("src2", `TCU_SRC2_ADDR, 0);
            rchk("flags", `TCU_FLAG_ADDR, 0);
            rchk("mask", `TCU_MASK_ADDR, 0);
            reg_rd(8'h40);
            chk("unmapr", `TCU_RESP_SLVERR, rsp);
            reg_wr(8'h44, 32'hff);
            chk("unmapw", `TCU_RESP_SLVERR, rsp);
        end
    endtask
    task t_modes;
        integer m, i, n;
        reg [31:0] tv;
        begin
            for (m = 4; m < 8; m = m + 1) begin
                n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
                reg_wr(`TCU_CTRL1_ADDR, 0);
                reg_wr(`TCU_CTRL1_ADDR, 32'h80 + m);
                if (n > 1) begin
                    repeat (2) ev(0, 0);
                    reg_wr(`TCU_CTRL1_ADDR, 0);
                    reg_wr(`TCU_CTRL1_ADDR, 32'h80 + m);
                end
                reg_wr(`TCU_FLAG_ADDR, 3);
                tsnap(tv);
                for (i = 1; i < n; i = i + 1) ev(0, 0);
                wt;
                rchk("early", `TCU_FLAG_ADDR, 0);
                ev(0, 0);
                wt;
                rchk("flag", `TCU_FLAG_ADDR, 1);
                rchk("value", `TCU_VAL1_ADDR, tv);
            end
            // prescale switch without clearing keeps the count
            reg_wr(`TCU_CTRL1_ADDR, 0);
            reg_wr(`TCU_CTRL1_ADDR, 32'h86);
            repeat (2) ev(0, 0);
            reg_wr(`TCU_CTRL1_ADDR, 32'h87);
            reg_wr(`TCU_FLAG_ADDR, 3);
            repeat (13) ev(0, 0);
            wt;
            rchk("keep", `TCU_FLAG_ADDR, 0);
            ev(0, 0);
            wt;
            rchk("keep16", `TCU_FLAG_ADDR, 1);
        end
    endtask
    task t_irq;
        reg [31:0] tv;
        begin
            reg_wr(`TCU_CTRL1_ADDR, 0);
            reg_wr(`TCU_CTRL1_ADDR, 32'h85);
            reg_wr(`TCU_FLAG_ADDR, 3);
            ev(0, 0);
            tsnap(tv);
            ev(0, 0);
            wt;
            rchk("ovrwr", `TCU_VAL1_ADDR, tv);
            // bit 6 reads zero; alignment bit moves the value to the top half
            reg_wr(`TCU_CTRL1_ADDR, 32'hd5);
            rchk("ctrlrd", `TCU_CTRL1_ADDR, 32'h95);
            rchk("align", `TCU_VAL1_ADDR, tv << 16);
            repeat (30) @(posedge clk);
            rchk("stick", `TCU_FLAG_ADDR, 1);
            irqchk(0);
            reg_wr(`TCU_MASK_ADDR, 1);
            irqchk(1);
            reg_wr(`TCU_MASK_ADDR, 2);
            irqchk(0);
            reg_wr(`TCU_MASK_ADDR, 1);
            reg_wr(`TCU_FLAG_ADDR, 1);
            irqchk(0);
            rchk("clear", `TCU_FLAG_ADDR, 0);
        end
    endtask
    task t_src;
        integer k;
        reg [31:0] tv;
        begin
            reg_wr(`TCU_CTRL1_ADDR, 0);
            tsnap(tv);
            for (k = 0; k < 8; k = k + 1) begin
                reg_wr(`TCU_CTRL2_ADDR, 0);
                reg_wr(`TCU_SRC2_ADDR, k);
                reg_wr(`TCU_CTRL2_ADDR, 32'h85);
                reg_wr(`TCU_FLAG_ADDR, 3);
                ev(1, (k + 1) % 8);
                ev(0, 0);
                wt;
                rchk("other", `TCU_FLAG_ADDR, 0);
                ev(1, k);
                wt;
                rchk("src", `TCU_FLAG_ADDR, 2);
            end
            rchk("val2", `TCU_VAL2_ADDR, tv);
            reg_wr(`TCU_CTRL2_ADDR, 0);
            reg_wr(`TCU_CTRL1_ADDR, 32'h05);
            reg_wr(`TCU_FLAG_ADDR, 3);
            ev(0, 0);
            reg_wr(`TCU_CTRL1_ADDR, 32'h83);
            ev(0, 0);
            wt;
            rchk("off", `TCU_FLAG_ADDR, 0);
        end
    endtask
    initial begin
        #2_000_000;
        miscompares = miscompares + 1;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_modes;
        t_irq;
        t_src;
        finish_test;
    end
endmodule // timer_capture_unit_tb
